// *** fsb_pkg.sv ***
// Constants, types and shared helpers of the synchronous burst read engine.
// Assumes one 200 MHz system clock; the burst clock is a sampled input pin.
package fsb_pkg;
    localparam int          ADDR_W       = 24;
    localparam int          DATA_W       = 16;
    localparam int          FIFO_DEPTH   = 8;
    localparam logic [2:0]  WS_EDGE5     = 3'h3;
    localparam logic [2:0]  WS_EDGE7     = 3'h5;
    localparam logic [2:0]  WS_BIAS      = 3'h2;
    localparam logic [2:0]  WS_FALLBACK  = 3'h7;
    localparam logic [2:0]  LEN_CONT     = 3'h0;
    localparam logic [2:0]  LEN_8        = 3'h2;
    localparam logic [2:0]  LEN_16       = 3'h3;
    localparam logic [2:0]  LEN_32       = 3'h4;
    localparam logic [5:0]  WORDS_8      = 6'h08;
    localparam logic [5:0]  WORDS_16     = 6'h10;
    localparam logic [5:0]  WORDS_32     = 6'h20;
    localparam logic [23:0] MASK_8       = 24'h000007;
    localparam logic [23:0] MASK_16      = 24'h00000F;
    localparam logic [23:0] MASK_32      = 24'h00001F;
    localparam logic [6:0]  LINE_START   = 7'h00;
    localparam logic        RST_SYNC     = 1'b0;
    localparam logic        RST_BOUNDARY = 1'b1;
    localparam logic [2:0]  RST_WAIT     = 3'h5;
    localparam logic [2:0]  RST_LEN      = 3'h0;
    localparam logic        RST_WRAP     = 1'b1;

    typedef enum logic [2:0] {ST_IDLE, ST_LAT, ST_STREAM, ST_STATUS, ST_DONE} fsb_state_e;

    // Group mask of a linear length; zero for continuous and reserved codes.
    function automatic logic [23:0] fsb_mask(input logic [2:0] len);
        fsb_mask = (len == LEN_8) ? MASK_8 : (len == LEN_16) ? MASK_16 : (len == LEN_32) ? MASK_32 : 24'h000000;
    endfunction

    // Next burst address: wraps inside the group in wrap mode, else counts up and rolls over at the top.
    function automatic logic [23:0] fsb_next(input logic [23:0] a, input logic [2:0] len, input logic wrap);
        logic [23:0] inc;
        logic [23:0] m;
        inc = a + 24'h000001;
        m   = fsb_mask(len);
        fsb_next = wrap ? ((a & ~m) | (inc & m)) : inc;
    endfunction
endpackage

// *** fsb_fifo_if.sv ***
// Valid/ready carrier between the burst engine and its word FIFO.
// Assumes both ends run on the same system clock.
`timescale 1ns/10ps
`default_nettype none
interface fsb_fifo_if #(parameter int W = 17);
    logic         in_valid;
    logic         in_ready;
    logic [W-1:0] in_data;
    logic         out_valid;
    logic         out_ready;
    logic [W-1:0] out_data;
    logic         flush;
    modport fifo_side (input in_valid, in_data, out_ready, flush, output in_ready, out_valid, out_data);
    modport user_side (output in_valid, in_data, out_ready, flush, input in_ready, out_valid, out_data);
endinterface
`default_nettype wire

// *** fsb_fifo.sv ***
// Word FIFO of flip-flops between array prefetch and burst output.
// Assumes flush and traffic come on the system clock; flush wins over a push.
`timescale 1ns/10ps
`default_nettype none
module fsb_fifo #(
    parameter int W     = 17,
    parameter int DEPTH = 8
) (
    input  wire logic i_mclk,
    input  wire logic i_rst_b,
    fsb_fifo_if.fifo_side f
);
    localparam int             AW   = $clog2(DEPTH);
    localparam logic [AW:0]    FULL = (AW + 1)'(DEPTH);
    localparam logic [AW-1:0]  LAST = AW'(DEPTH - 1);

    logic [W-1:0]  mem [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0]   cnt_q;
    wire           push = f.in_valid & f.in_ready;
    wire           pop  = f.out_valid & f.out_ready;

    // Full and empty come from the count, so the filling side really stalls.
    assign f.in_ready  = (cnt_q != FULL);
    assign f.out_valid = (cnt_q != '0);
    assign f.out_data  = mem[rd_q];

    // One storage word per entry, written when the write pointer selects it.
    for (genvar g = 0; g < DEPTH; g++) begin : g_word
        localparam logic [AW-1:0] IDX = AW'(g);
        always_ff @(posedge i_mclk) begin
            if (push && (wr_q == IDX)) begin
                mem[g] <= f.in_data;
            end
        end
    end

    // Pointers and count; a flush empties the queue at once.
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else if (f.flush) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= (wr_q == LAST) ? '0 : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == LAST) ? '0 : rd_q + 1'b1;
            end
            cnt_q <= cnt_q + (AW + 1)'(push) - (AW + 1)'(pop);
        end
    end

    a_fifo_bound : assert property (@(posedge i_mclk) disable iff (!i_rst_b) cnt_q <= FULL)
        else $error("fifo count above depth");
endmodule
`default_nettype wire

// *** fsb_burst.sv ***
// Synchronous burst read engine: latency, wait insertion, burst modes and termination.
// Assumes all pins are synchronous to i_mclk and the burst clock is far slower than it.
// The array answers combinationally for the address on o_array_addr in the same cycle.
`timescale 1ns/10ps
`default_nettype none
module fsb_burst (
    input  wire logic        i_mclk,
    input  wire logic        i_rst_b,
    input  wire logic        i_ce_b,
    input  wire logic        i_address_valid_strobe_n,
    input  wire logic [23:0] i_addr,
    input  wire logic        i_burst_clk,
    input  wire logic        i_cfg_load,
    input  wire logic        i_cfg_sync_en,
    input  wire logic        i_cfg_boundary_wait,
    input  wire logic [2:0]  i_initial_wait_field,
    input  wire logic [2:0]  i_burst_length_field,
    input  wire logic        i_wrap_enable_bit,
    input  wire logic [15:0] i_array_data,
    input  wire logic        i_bank_busy,
    input  wire logic [15:0] i_status_word,
    output logic      [15:0] o_dq,
    output logic             o_dq_oe_b,
    output logic             o_rdy,
    output logic      [23:0] o_array_addr,
    output logic             o_burst_active
);
    fsb_fifo_if #(.W(fsb_pkg::DATA_W + 1)) ff ();

    logic                bclk_q;
    logic                avd_q;
    logic [23:0]         hold_addr_q;
    logic                cfg_sync_q;
    logic                cfg_bnd_q;
    logic [2:0]          cfg_wait_q;
    logic [2:0]          cfg_len_q;
    logic                cfg_wrap_q;
    fsb_pkg::fsb_state_e st_q;
    fsb_pkg::fsb_state_e st_d;
    logic [2:0]          len_q;
    logic                wrap_q;
    logic [2:0]          lat_cnt_q;
    logic [2:0]          lat_sel_q;
    logic [2:0]          wait_cnt_q;
    logic [1:0]          align_q;
    logic [23:0]         out_addr_q;
    logic [5:0]          remain_q;
    logic [23:0]         pf_addr_q;
    logic [5:0]          pf_left_q;
    logic                pf_run_q;
    logic [15:0]         dq_q;
    logic                rdy_q;
    logic                oe_b_q;

    // Strobe and clock edges are found against the previous sample of each pin.
    wire        bedge     = i_burst_clk & ~bclk_q;
    wire        avd_rise  = i_address_valid_strobe_n & ~avd_q & ~i_ce_b;
    wire        start     = avd_rise & cfg_sync_q;
    wire [2:0]  lat_edges = (cfg_wait_q >= fsb_pkg::WS_EDGE5 && cfg_wait_q <= fsb_pkg::WS_EDGE7) ?
                            cfg_wait_q + fsb_pkg::WS_BIAS : fsb_pkg::WS_FALLBACK;
    wire        cfg_lin   = (cfg_len_q == fsb_pkg::LEN_8) | (cfg_len_q == fsb_pkg::LEN_16) |
                            (cfg_len_q == fsb_pkg::LEN_32);
    wire [5:0]  cfg_words = (cfg_len_q == fsb_pkg::LEN_8)  ? fsb_pkg::WORDS_8 :
                            (cfg_len_q == fsb_pkg::LEN_16) ? fsb_pkg::WORDS_16 :
                            (cfg_len_q == fsb_pkg::LEN_32) ? fsb_pkg::WORDS_32 : 6'h00;
    wire        linear    = (len_q == fsb_pkg::LEN_8) | (len_q == fsb_pkg::LEN_16) | (len_q == fsb_pkg::LEN_32);

    // Address stepping is shared by the prefetcher and the output stage.
    wire [23:0] out_next  = fsb_pkg::fsb_next(out_addr_q, len_q, wrap_q & linear);
    wire [23:0] pf_next   = fsb_pkg::fsb_next(pf_addr_q, len_q, wrap_q & linear);
    wire        lin_end   = linear & (remain_q == 6'h00);

    // A word is due on an edge once latency and inserted waits are spent.
    wire        lat_last  = (st_q == fsb_pkg::ST_LAT) & (lat_cnt_q == 3'h1);
    wire        str_due   = (st_q == fsb_pkg::ST_STREAM) & (wait_cnt_q == 3'h0) & ~lin_end;
    wire        word_edge = bedge & (lat_last | str_due) & ~start & ~i_ce_b;
    wire        pop       = word_edge & ff.out_valid;
    wire        busy_word = ff.out_data[fsb_pkg::DATA_W];
    wire        deliver   = pop & ~busy_word;
    wire        hit_stat  = pop & busy_word;

    // Waits owed before the word at the next address.
    wire        align_hit = (out_next[1:0] == 2'b00);
    wire        bnd_hit   = cfg_bnd_q & (out_next[6:0] == fsb_pkg::LINE_START) &
                            ~(linear & wrap_q);
    wire [2:0]  wait_add  = (align_hit ? {1'b0, align_q} : 3'h0) + {2'b00, bnd_hit};

    // Prefetch pushes one array word per system cycle while the FIFO has room.
    wire        pf_push   = pf_run_q & ~start & ff.in_ready;
    wire        pf_stop   = i_bank_busy | (linear & (pf_left_q == 6'h01));
    assign ff.in_valid  = pf_run_q & ~start;
    assign ff.in_data   = {i_bank_busy, i_bank_busy ? i_status_word : i_array_data};
    assign ff.out_ready = word_edge;
    assign ff.flush     = start | i_ce_b;

    fsb_fifo #(.W(fsb_pkg::DATA_W + 1), .DEPTH(fsb_pkg::FIFO_DEPTH)) u_fifo (
        .i_mclk  (i_mclk),
        .i_rst_b (i_rst_b),
        .f       (ff.fifo_side)
    );

    // Burst state: chip select and reset end everything, a new strobe restarts.
    always_comb begin
        st_d = st_q;
        case (st_q)
            fsb_pkg::ST_IDLE:   st_d = fsb_pkg::ST_IDLE;
            fsb_pkg::ST_LAT:    st_d = deliver ? fsb_pkg::ST_STREAM : (hit_stat ? fsb_pkg::ST_STATUS : st_q);
            fsb_pkg::ST_STREAM: begin
                if (hit_stat) begin
                    st_d = fsb_pkg::ST_STATUS;
                end else if (bedge && lin_end) begin
                    st_d = fsb_pkg::ST_DONE;
                end
            end
            fsb_pkg::ST_STATUS: st_d = fsb_pkg::ST_STATUS;
            fsb_pkg::ST_DONE:   st_d = fsb_pkg::ST_DONE;
            default:            st_d = fsb_pkg::ST_IDLE;
        endcase
        if (start) begin
            st_d = fsb_pkg::ST_LAT;
        end
        if (i_ce_b || !cfg_sync_q) begin
            st_d = fsb_pkg::ST_IDLE;
        end
    end

    // Pin samples and the address held while the strobe is low.
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            bclk_q      <= 1'b0;
            avd_q       <= 1'b1;
            hold_addr_q <= 24'h000000;
        end else begin
            bclk_q <= i_burst_clk;
            avd_q  <= i_address_valid_strobe_n;
            if (!i_address_valid_strobe_n) begin
                hold_addr_q <= i_addr;
            end
        end
    end

    // Configuration comes up asynchronous and with its defaults.
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cfg_sync_q <= fsb_pkg::RST_SYNC;
            cfg_bnd_q  <= fsb_pkg::RST_BOUNDARY;
            cfg_wait_q <= fsb_pkg::RST_WAIT;
            cfg_len_q  <= fsb_pkg::RST_LEN;
            cfg_wrap_q <= fsb_pkg::RST_WRAP;
        end else if (i_cfg_load) begin
            cfg_sync_q <= i_cfg_sync_en;
            cfg_bnd_q  <= i_cfg_boundary_wait;
            cfg_wait_q <= i_initial_wait_field;
            cfg_len_q  <= i_burst_length_field;
            cfg_wrap_q <= i_wrap_enable_bit;
        end
    end

    // Output stage: counters load on a strobe rise and otherwise move only on active burst clock edges.
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            st_q       <= fsb_pkg::ST_IDLE;
            len_q      <= fsb_pkg::RST_LEN;
            wrap_q     <= fsb_pkg::RST_WRAP;
            lat_cnt_q  <= 3'h0;
            lat_sel_q  <= 3'h0;
            wait_cnt_q <= 3'h0;
            align_q    <= 2'b00;
            out_addr_q <= 24'h000000;
            remain_q   <= 6'h00;
        end else begin
            st_q <= st_d;
            if (start) begin
                len_q      <= cfg_len_q;
                wrap_q     <= cfg_wrap_q;
                lat_cnt_q  <= lat_edges;
                lat_sel_q  <= lat_edges;
                wait_cnt_q <= 3'h0;
                align_q    <= hold_addr_q[1:0];
                out_addr_q <= hold_addr_q;
                remain_q   <= cfg_words;
            end else if (bedge && st_q == fsb_pkg::ST_LAT && lat_cnt_q != 3'h1) begin
                lat_cnt_q <= lat_cnt_q - 3'h1;
            end else if (bedge && st_q == fsb_pkg::ST_STREAM && wait_cnt_q != 3'h0) begin
                wait_cnt_q <= wait_cnt_q - 3'h1;
            end else if (deliver) begin
                out_addr_q <= out_next;
                remain_q   <= linear ? remain_q - 6'h01 : remain_q;
                wait_cnt_q <= wait_add;
                align_q    <= align_hit ? 2'b00 : align_q;
            end
        end
    end

    // Prefetcher walks the same address sequence ahead of the output stage.
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            pf_addr_q <= 24'h000000;
            pf_left_q <= 6'h00;
            pf_run_q  <= 1'b0;
        end else if (i_ce_b) begin
            pf_run_q <= 1'b0;
        end else if (start) begin
            pf_addr_q <= hold_addr_q;
            pf_left_q <= cfg_words;
            pf_run_q  <= 1'b1;
        end else if (pf_push) begin
            pf_addr_q <= pf_next;
            pf_left_q <= pf_left_q - 6'h01;
            pf_run_q  <= ~pf_stop;
        end
    end

    // Data pins: ready rises only with a delivered word and falls on any other edge.
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            dq_q   <= 16'h0000;
            rdy_q  <= 1'b0;
            oe_b_q <= 1'b1;
        end else if (i_ce_b || !cfg_sync_q) begin
            rdy_q  <= 1'b0;
            oe_b_q <= 1'b1;
        end else if (start) begin
            rdy_q  <= 1'b0;
            oe_b_q <= 1'b0;
        end else if (pop) begin
            dq_q  <= ff.out_data[fsb_pkg::DATA_W-1:0];
            rdy_q <= deliver;
        end else if (bedge) begin
            rdy_q <= 1'b0;
        end
    end

    assign o_dq           = dq_q;
    assign o_rdy          = rdy_q;
    assign o_dq_oe_b      = oe_b_q;
    assign o_array_addr   = pf_addr_q;
    assign o_burst_active = (st_q != fsb_pkg::ST_IDLE);

    // Helper counters that only the checks below read.
    logic [2:0] lat_seen_q;
    logic [5:0] words_q;
    logic [23:0] base_q;
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            lat_seen_q <= 3'h0;
            words_q    <= 6'h00;
            base_q     <= 24'h000000;
        end else if (start) begin
            lat_seen_q <= 3'h0;
            words_q    <= 6'h00;
            base_q     <= hold_addr_q & ~fsb_pkg::fsb_mask(cfg_len_q);
        end else begin
            if (bedge && st_q == fsb_pkg::ST_LAT && lat_seen_q != 3'h7) begin
                lat_seen_q <= lat_seen_q + 3'h1;
            end
            if (deliver && words_q != 6'h3F) begin
                words_q <= words_q + 6'h01;
            end
        end
    end

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_b);

    sequence s_start;
        avd_rise && cfg_sync_q;
    endsequence
    sequence s_first_word;
        (st_q == fsb_pkg::ST_LAT) && deliver;
    endsequence

    a_async_hold : assert property (!cfg_sync_q |=> st_q == fsb_pkg::ST_IDLE && !o_rdy)
        else $error("burst active while asynchronous");
    a_first_latency : assert property (s_first_word |-> lat_seen_q + 3'h1 >= lat_sel_q)
        else $error("first word before programmed latency");
    a_rdy_on_edge : assert property ($rose(o_rdy) |-> $past(bedge))
        else $error("ready rose without a burst clock edge");
    a_addr_step : assert property (deliver && !i_ce_b |=> out_addr_q == $past(out_next))
        else $error("burst address did not advance");
    a_wait_quiet : assert property (bedge && st_q == fsb_pkg::ST_STREAM && wait_cnt_q != 3'h0
                                    && !start && !i_ce_b |=> !o_rdy)
        else $error("ready active in a wait state");
    a_ce_end : assert property (i_ce_b |=> st_q == fsb_pkg::ST_IDLE ##1 o_dq_oe_b && !o_rdy)
        else $error("chip select did not end burst");
    a_avd_restart : assert property ((s_start and !i_ce_b) |=> st_q == fsb_pkg::ST_LAT && !o_rdy)
        else $error("strobe did not restart burst");
    a_status_stall : assert property (st_q == fsb_pkg::ST_STATUS && !avd_rise && !i_ce_b |=>
                                      st_q == fsb_pkg::ST_STATUS && !o_rdy)
        else $error("clock not ignored during status");
    a_linear_count : assert property (linear && st_q != fsb_pkg::ST_IDLE |-> words_q <= fsb_pkg::WORDS_32
                                      && (st_q != fsb_pkg::ST_DONE || remain_q == 6'h00))
        else $error("linear burst word count wrong");
    a_wrap_group : assert property (linear && wrap_q && deliver |=>
                                    (out_addr_q & ~fsb_pkg::fsb_mask(len_q)) == base_q)
        else $error("wrap burst left its group");
endmodule
`default_nettype wire

// *** fsb_host_model.sv ***
// Host memory controller model: chip select, address strobe, address bus and burst clock.
// Assumes the testbench calls its tasks; every change lands just after a rising i_mclk edge.
`timescale 1ns/10ps
`default_nettype none
module fsb_host_model (
    input  wire logic        i_mclk,
    output logic             o_ce_b,
    output logic             o_strobe_n,
    output wire logic [23:0] o_addr,
    output logic             o_burst_clk
);
    logic [23:0] addr_q;
    logic        tick_q;
    // A released bus shows a pattern that changes every cycle, so a late latch never sees a stale match.
    assign o_addr = o_strobe_n ? (~addr_q ^ {12{tick_q, ~tick_q}}) : addr_q;
    initial begin
        o_ce_b      = 1'b1;
        o_strobe_n  = 1'b1;
        o_burst_clk = 1'b0;
        addr_q      = 24'h000000;
        tick_q      = 1'b0;
    end
    always @(posedge i_mclk) begin
        tick_q <= ~tick_q;
    end
    // Strobe low for two cycles with the address held; a strobe during a burst abandons it.
    task automatic start(input logic [23:0] a);
        @(posedge i_mclk);
        o_ce_b     <= 1'b0;
        o_strobe_n <= 1'b0;
        addr_q     <= a;
        repeat (2) @(posedge i_mclk);
        o_strobe_n <= 1'b1;
        repeat (3) @(posedge i_mclk);
    endtask
    // The burst clock runs only inside a burst and is parked low otherwise.
    task automatic edges(input int n, input int half);
        repeat (n) begin
            repeat (half) @(posedge i_mclk);
            o_burst_clk <= 1'b1;
            repeat (half) @(posedge i_mclk);
            o_burst_clk <= 1'b0;
        end
    endtask
    task automatic stop();
        @(posedge i_mclk);
        o_ce_b <= 1'b1;
    endtask
endmodule
`default_nettype wire

// *** fsb_burst_tb.sv ***
// Self-checking bench of the burst read engine: the driver queues one note per burst clock edge.
// Assumes the host model drives the pins and the array is a scrambled copy of its address.
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin failures++; $display("mismatch %s expected %h seen %h", n, e, g); end end
module fsb_burst_tb;
    localparam logic [15:0] STAT = 16'h0080;
    logic              i_mclk = 1'b0;
    logic              rst_b, cfg_load, sync, bnd, wrap, busy_en, exp_on, bclk_prev;
    logic [2:0]        wfld, lfld;
    logic [23:0]       busy_lo;
    logic [31:0]       rnd;
    logic [17:0]       exp_q[$];
    logic [17:0]       cur;
    int                failures = 0, compares = 0, cycles = 0, seed = 35668;
    int                wl[4] = '{3, 4, 5, 7};
    wire logic         ce_b, strobe_n, bclk, oe_b, rdy, active;
    wire logic [23:0]  addr, aaddr;
    wire logic [15:0]  dq;
    wire logic [15:0]  arr = dat(aaddr);
    wire logic         busy = busy_en && (aaddr >= busy_lo);
    fsb_host_model u_host (.i_mclk(i_mclk), .o_ce_b(ce_b), .o_strobe_n(strobe_n), .o_addr(addr), .o_burst_clk(bclk));
    fsb_burst u_dut (.i_mclk(i_mclk), .i_rst_b(rst_b), .i_ce_b(ce_b), .i_address_valid_strobe_n(strobe_n),
        .i_addr(addr), .i_burst_clk(bclk), .i_cfg_load(cfg_load), .i_cfg_sync_en(sync), .i_cfg_boundary_wait(bnd),
        .i_initial_wait_field(wfld), .i_burst_length_field(lfld), .i_wrap_enable_bit(wrap), .i_array_data(arr),
        .i_bank_busy(busy), .i_status_word(STAT), .o_dq(dq), .o_dq_oe_b(oe_b), .o_rdy(rdy),
        .o_array_addr(aaddr), .o_burst_active(active));
    initial begin
        forever #2.5 i_mclk = ~i_mclk;
    end
    // A scrambled address as data makes a wrong word address visible.
    function automatic logic [15:0] dat(input logic [23:0] p);
        dat = p[15:0] ^ {p[23:16], 8'hA5};
    endfunction
    task automatic print_verdict();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // A hang counts as a failure; the ceiling is nearly three times the planned run.
    always @(posedge i_mclk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            print_verdict();
        end
    end
    // At each burst clock edge the host captures what the previous edge produced.
    always @(posedge i_mclk) begin
        bclk_prev <= bclk;
        if (bclk && !bclk_prev && exp_q.size() > 0) begin
            cur = exp_q.pop_front();
            `CHK("rdy", cur[16], rdy)
            if (cur[17]) `CHK("dq", cur[15:0], dq)
        end
    end
    // Notes one expectation per edge: latency, alignment and line waits, group order, end and status.
    task automatic plan(input logic [23:0] a, input int e);
        logic [23:0] p, pn, m;
        logic [17:0] x;
        int          n, lim, cnt, waits;
        bit          done, stat, algn;
        p = a;
        cnt = 0;
        waits = 0;
        done = 0;
        stat = 0;
        algn = (a[1:0] == 2'h0);
        n = (wfld >= 3'h3 && wfld <= 3'h5) ? int'(wfld) + 2 : 7;
        lim = (lfld == 3'h2) ? 8 : (lfld == 3'h3) ? 16 : (lfld == 3'h4) ? 32 : 0;
        m = (lim > 0) ? 24'(lim - 1) : 24'h000000;
        exp_q.push_back(18'h00000);
        for (int j = 1; j < e; j++) begin
            x = {stat, 1'b0, STAT};
            if (exp_on && j >= n && !done) begin
                if (waits > 0) waits--;
                else begin
                    stat = busy_en && (p >= busy_lo);
                    x = stat ? {2'b10, STAT} : {2'b11, dat(p)};
                    cnt++;
                    done = stat || (cnt == lim);
                    pn = (wrap && lim > 0) ? ((p & ~m) | ((p + 24'h000001) & m)) : p + 24'h000001;
                    if (!algn && pn[1:0] == 2'h0) begin
                        waits = a[1:0];
                        algn = 1;
                    end
                    if (bnd && pn[6:0] == 7'h00 && !(wrap && lim > 0)) waits++;
                    p = pn;
                end
            end
            exp_q.push_back(x);
        end
    endtask
    task automatic cfg(input logic s, input logic b, input logic [2:0] w, input logic [2:0] l, input logic r);
        @(posedge i_mclk);
        sync <= s;
        bnd <= b;
        wfld <= w;
        lfld <= l;
        wrap <= r;
        cfg_load <= 1'b1;
        @(posedge i_mclk);
        cfg_load <= 1'b0;
        exp_on = s;
    endtask
    task automatic burst(input string name, input logic [23:0] a, input int e, input int half, input bit fin);
        plan(a, e);
        u_host.start(a);
        `CHK("oe_b_on", ~exp_on, oe_b)
        u_host.edges(e, half);
        if (fin) begin
            u_host.stop();
            repeat (2) @(posedge i_mclk);
            `CHK("oe_b_off", 1'b1, oe_b)
            `CHK("active", 1'b0, active)
        end
        $display("test %s done", name);
    endtask
    initial begin
        rst_b = 1'b0;
        cfg_load = 1'b0;
        {sync, bnd, wrap, busy_en, exp_on} = 5'b01100;
        wfld = 3'h5;
        lfld = 3'h0;
        busy_lo = 24'h000000;
        repeat (3) @(posedge i_mclk);
        rst_b <= 1'b1;
        burst("async", 24'h000040, 10, 4, 1);
        foreach (wl[i]) for (int o = 0; o < 4; o++) begin
            cfg(1'b1, 1'b1, 3'(wl[i]), 3'h0, 1'b1);
            rnd = $random(seed);
            burst("latency", {rnd[16:0], 7'h7C | 7'(o)}, 16, 4, o == 3);
        end
        cfg(1'b1, 1'b0, 3'h3, 3'h0, 1'b1);
        burst("no_boundary", 24'h0003FD, 12, 4, 1);
        cfg(1'b1, 1'b1, 3'h3, 3'h0, 1'b1);
        burst("top_wrap", 24'hFFFFFE, 12, 7, 1);
        for (int l = 2; l <= 4; l++) for (int r = 0; r < 2; r++) for (int s = 0; s < 2; s++) begin
            cfg(1'b1, 1'b1, 3'h4, 3'(l), 1'(r));
            rnd = $random(seed);
            burst("linear", {rnd[16:0], s ? 7'h7B : 7'h05}, 44, 4, 0);
        end
        cfg(1'b1, 1'b1, 3'h3, 3'h0, 1'b1);
        burst("abort", 24'h000101, 9, 4, 0);
        burst("restart", 24'h000230, 12, 4, 1);
        busy_lo <= 24'h000208;
        busy_en <= 1'b1;
        @(posedge i_mclk);
        burst("busy", 24'h000203, 16, 4, 0);
        busy_en <= 1'b0;
        @(posedge i_mclk);
        burst("resume", 24'h000208, 12, 4, 1);
        u_host.start(24'h000010);
        u_host.edges(3, 4);
        rst_b <= 1'b0;
        exp_on = 1'b0;
        repeat (2) @(posedge i_mclk);
        `CHK("rst_rdy", 1'b0, rdy)
        `CHK("rst_dq", 16'h0000, dq)
        `CHK("rst_oe_b", 1'b1, oe_b)
        rst_b <= 1'b1;
        burst("after_reset", 24'h000010, 10, 4, 1);
        print_verdict();
    end
endmodule
`default_nettype wire
